//--- rtl/gpw_pkg.sv
// Constants for the general-purpose port block: register indices, pin masks and reset values.
// Assumes the core addresses the registers as data-memory locations by index.
package gpw_pkg;

  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_W;
  localparam int NUM_REGS = 23;
  localparam int ADDR_W = 5;
  localparam int DRV_W = 24;

  // ----------------------------------------
  // Register indices, port A at element 0.
  // ----------------------------------------
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] DATA_IDX = {5'h10, 5'h0d, 5'h0a, 5'h07, 5'h04, 5'h00};
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] DIR_IDX = {5'h11, 5'h0e, 5'h0b, 5'h08, 5'h05, 5'h01};
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] PU_IDX = {5'h12, 5'h0f, 5'h0c, 5'h09, 5'h06, 5'h02};
  localparam logic [ADDR_W-1:0] WAKE_IDX = 5'h03;
  localparam logic [ADDR_W-1:0] STRENGTH_IDX = 5'h13;
  localparam logic [ADDR_W-1:0] DRIVE0_IDX = 5'h14;
  localparam logic [ADDR_W-1:0] DRIVE1_IDX = 5'h15;
  localparam logic [ADDR_W-1:0] DRIVE2_IDX = 5'h16;

  // ----------------------------------------
  // Implemented bits and reset values.
  // ----------------------------------------
  localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PIN_MASK = {8'hcf, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff};
  localparam logic [PORT_W-1:0] STRENGTH_MASK = 8'h01;
  localparam logic [PORT_W-1:0] FULL_MASK = 8'hff;
  localparam logic [PORT_W-1:0] DATA_RST = 8'hff;
  localparam logic [PORT_W-1:0] DIR_RST = 8'hff;
  localparam logic [PORT_W-1:0] CLEAR_RST = 8'h00;
  localparam int STRENGTH_BIT = 0;

endpackage

//--- rtl/gpw_ports.sv
// Six eight-bit general-purpose ports with pull-ups, port A wake-up and source drive select.
// Assumes a single-cycle data-memory access port from the core and pads handled outside.
// How it works
// - Reads of input pins return the synchronised live pin level; no input latch exists.
// - Written data sits in the output latch and drives unchanged until rewritten.
// - Direction bit one makes an input, zero a push-pull output, changeable anytime.
// - Reading an output pin returns the output latch, not the pin level.
// - Pull-up enable works only for digital input or NMOS output functions.
// - One global strength bit picks weak or strong for enabled pull-ups only.
// - A falling level on a wake-enabled port A pin wakes sleep or idle.
// - Wake-up acts only for GPIO input pins while the core sleeps or idles.
// - The wake enable register holds one enable bit per port A pin.
// - Drive is four-level, one two-bit field per pin group, four per register.
// - Top field of drive register zero sets port B pins seven to four.
// - Drive code 00 is minimum, 11 maximum, ascending between.
// - Unimplemented register bits read zero and ignore writes.
// - Registers take their reset values on ordinary resets but hold through watchdog time-out in sleep.
`timescale 1ns/1ns
`default_nettype none

module gpw_ports
  import gpw_pkg::*;
(
  input wire logic core_clk, // System clock, 20 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic keepOnReset, // High with rst for a watchdog time-out in sleep.
  input wire logic [gpw_pkg::ADDR_W-1:0] memAddr, // Register index.
  input wire logic memWrEn, // Write strobe.
  input wire logic [gpw_pkg::PORT_W-1:0] memWrData, // Write data.
  input wire logic memRdEn, // Read strobe.
  output logic [gpw_pkg::PORT_W-1:0] memRdData, // Read data, one cycle after strobe.
  input wire logic [gpw_pkg::NUM_PINS-1:0] pinIn, // Pad input levels, asynchronous.
  output logic [gpw_pkg::NUM_PINS-1:0] pinOut, // Pad output levels.
  output logic [gpw_pkg::NUM_PINS-1:0] pinOe, // Pad output enables.
  input wire logic [gpw_pkg::NUM_PINS-1:0] pinGpio, // Pin function is general purpose.
  input wire logic [gpw_pkg::NUM_PINS-1:0] pinNmos, // Pin function is an NMOS output.
  output logic [gpw_pkg::NUM_PINS-1:0] pullOn, // Pull-up switched on, weak or strong.
  output logic [gpw_pkg::NUM_PINS-1:0] pullStrong, // Pull-up uses the strong setting.
  output logic [gpw_pkg::DRV_W-1:0] driveLevel, // Source drive fields, twelve groups.
  input wire logic sleepMode, // Core is in sleep or idle.
  output logic wakeReq // One-cycle wake request.
);
  import gpw_pkg::*;

  initial begin
    if (NUM_REGS > (1 << ADDR_W)) begin
      $error("register count does not fit the index width");
    end
  end

  // ----------------------------------------
  // Decoding helpers.
  // ----------------------------------------
  function automatic logic [PORT_W-1:0] regMask(input logic [ADDR_W-1:0] idx);
    logic [PORT_W-1:0] m;
    m = (idx < ADDR_W'(NUM_REGS)) ? FULL_MASK : CLEAR_RST;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (idx == DATA_IDX[p] || idx == DIR_IDX[p] || idx == PU_IDX[p]) begin
        m = PIN_MASK[p];
      end
    end
    if (idx == STRENGTH_IDX) begin
      m = STRENGTH_MASK;
    end
    return m;
  endfunction

  function automatic logic [PORT_W-1:0] regRst(input logic [ADDR_W-1:0] idx);
    logic [PORT_W-1:0] v;
    v = CLEAR_RST;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (idx == DATA_IDX[p]) begin
        v = DATA_RST & PIN_MASK[p];
      end else if (idx == DIR_IDX[p]) begin
        v = DIR_RST & PIN_MASK[p];
      end
    end
    return v;
  endfunction

  // ----------------------------------------
  // Register storage.
  // ----------------------------------------
  logic [PORT_W-1:0] regs_r [NUM_REGS];
  logic [NUM_PINS-1:0] pinMeta_r;
  logic [NUM_PINS-1:0] pinSync_r;
  logic [NUM_PINS-1:0] pinPrev_r;
  logic [NUM_PINS-1:0] latchAll;
  logic [NUM_PINS-1:0] dirAll;
  logic [NUM_PINS-1:0] puAll;
  logic [NUM_PINS-1:0] maskAll;
  logic [PORT_W-1:0] rdNxt;
  logic [PORT_W-1:0] wakeEn;
  logic [PORT_W-1:0] wakeFall;
  logic wakeReq_r;
  logic wakeReq_nxt;
  logic [PORT_W-1:0] memRdData_r;

  // A watchdog time-out in sleep must not disturb the port setup the wake-up relies on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      if (!keepOnReset) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          regs_r[i] <= regRst(ADDR_W'(i));
        end
      end
    end else if (memWrEn && memAddr < ADDR_W'(NUM_REGS)) begin
      regs_r[memAddr] <= memWrData & regMask(memAddr);
    end
  end

  // ----------------------------------------
  // Pin synchroniser.
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
      pinPrev_r <= '0;
    end else begin
      pinMeta_r <= pinIn;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // ----------------------------------------
  // Pin drive, pull-ups and drive level.
  // ----------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign latchAll[p*PORT_W +: PORT_W] = regs_r[DATA_IDX[p]];
    assign dirAll[p*PORT_W +: PORT_W] = regs_r[DIR_IDX[p]];
    assign puAll[p*PORT_W +: PORT_W] = regs_r[PU_IDX[p]];
    assign maskAll[p*PORT_W +: PORT_W] = PIN_MASK[p];
  end

  assign pinOut = latchAll & maskAll;
  assign pinOe = ~dirAll & maskAll & pinGpio;
  assign pullOn = puAll & maskAll & (pinNmos | (pinGpio & dirAll));
  assign pullStrong = pullOn & {NUM_PINS{regs_r[STRENGTH_IDX][STRENGTH_BIT]}};
  // Field order per register: low groups first, so bits 7:6 of register zero drive port B 7..4.
  assign driveLevel = {regs_r[DRIVE2_IDX], regs_r[DRIVE1_IDX], regs_r[DRIVE0_IDX]};

  // ----------------------------------------
  // Register read.
  // ----------------------------------------
  always_comb begin
    rdNxt = CLEAR_RST;
    if (memAddr < ADDR_W'(NUM_REGS)) begin
      rdNxt = regs_r[memAddr] & regMask(memAddr);
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (memAddr == DATA_IDX[p]) begin
        rdNxt = ((regs_r[DATA_IDX[p]] & ~regs_r[DIR_IDX[p]])
                | (pinSync_r[p*PORT_W +: PORT_W] & regs_r[DIR_IDX[p]])) & PIN_MASK[p];
      end
    end
  end

  // The pin is sampled once per read; the source must be settled two cycles earlier.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      memRdData_r <= CLEAR_RST;
    end else if (memRdEn) begin
      memRdData_r <= rdNxt;
    end
  end
  assign memRdData = memRdData_r;

  // ----------------------------------------
  // Port A wake-up.
  // ----------------------------------------
  assign wakeEn = regs_r[WAKE_IDX] & regs_r[DIR_IDX[0]] & pinGpio[PORT_W-1:0];
  assign wakeFall = pinPrev_r[PORT_W-1:0] & ~pinSync_r[PORT_W-1:0];
  assign wakeReq_nxt = sleepMode && |(wakeFall & wakeEn);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wakeReq_r <= 1'b0;
    end else begin
      wakeReq_r <= wakeReq_nxt;
    end
  end
  assign wakeReq = wakeReq_r;

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking

  AST_READ_LIVE: assert property (disable iff (rst)
    memRdEn && memAddr == DATA_IDX[0] && regs_r[DIR_IDX[0]] == FULL_MASK
    |=> memRdData == $past(pinSync_r[PORT_W-1:0]))
    else $error("input read did not return the pin level");
  AST_LATCH_HOLD: assert property (disable iff (rst)
    !(memWrEn && memAddr == DATA_IDX[1]) |=> pinOut[15:8] == $past(pinOut[15:8]))
    else $error("output latch changed without a write");
  AST_LATCH_WRITE: assert property (disable iff (rst)
    memWrEn && memAddr == DATA_IDX[0] |=> pinOut[PORT_W-1:0] == $past(memWrData))
    else $error("output latch did not take the write");
  AST_DIR_OE: assert property (disable iff (rst)
    memWrEn && memAddr == DIR_IDX[2] && pinGpio[23:16] == FULL_MASK
    |=> pinOe[23:16] == ~$past(memWrData))
    else $error("direction write did not steer the drivers");
  AST_READ_LATCH: assert property (disable iff (rst)
    memRdEn && memAddr == DATA_IDX[1] && regs_r[DIR_IDX[1]] == CLEAR_RST
    |=> memRdData == $past(pinOut[15:8]))
    else $error("output read did not return the latch");
  AST_PULL_GATE: assert property (disable iff (rst)
    pinGpio == '0 && pinNmos == '0 |-> pullOn == '0)
    else $error("pull-up on for an unsupported function");
  AST_STRENGTH: assert property (disable iff (rst)
    (pullStrong & ~pullOn) == '0)
    else $error("strength applied to a disabled pull-up");
  AST_WAKE: assert property (disable iff (rst)
    sleepMode && wakeFall[0] && wakeEn[0] |=> wakeReq)
    else $error("falling wake pin did not wake");
  AST_NO_WAKE_AWAKE: assert property (disable iff (rst)
    !sleepMode |=> !wakeReq)
    else $error("wake request outside sleep");
  AST_DRIVE_FIELD: assert property (disable iff (rst)
    memWrEn && memAddr == DRIVE0_IDX |=> driveLevel[7:6] == $past(memWrData[7:6]))
    else $error("drive field for port B upper pins wrong");
  AST_UNIMPL_READ: assert property (disable iff (rst)
    memRdEn && memAddr == STRENGTH_IDX |=> memRdData[7:1] == '0)
    else $error("unimplemented bits read nonzero");
  AST_ABSENT_PINS: assert property (disable iff (rst)
    pinOe[31] == 1'b0 && pinOe[47:45] != 3'h7 && pinOe[45:44] == 2'h0)
    else $error("absent pin driven");
  AST_SLEEP_KEEP: assert property (
    rst && keepOnReset && !$past(memWrEn) |=> pinOut == $past(pinOut) && driveLevel == $past(driveLevel))
    else $error("watchdog time-out in sleep disturbed the ports");
  AST_RESET_CLEAR: assert property (
    rst && !keepOnReset |=> pinOe == '0 && driveLevel == '0 && pullOn == '0)
    else $error("ordinary reset did not clear the ports");

  COV_WAKE: cover property (disable iff (rst) sleepMode ##1 wakeReq);
  COV_OUT_READ: cover property (disable iff (rst) memWrEn && memAddr == DIR_IDX[0] ##1 memRdEn);
  COV_SLEEP_RESET: cover property (rst && keepOnReset);

endmodule

`default_nettype wire

//--- rtl/gpw_dummy_unused.sv
// Holds no logic; every module of the port block lives in gpw_ports.sv.

//--- tb/gpw_pin_model.sv
// External circuitry on the port pins: switches that can overpower a pin, or the pull-up, or nothing.
// Assumes the bench sets the switch levels and enables; pad levels are resolved here for pinIn.
`timescale 1ns/1ns
`default_nettype none

module gpw_pin_model (
  input wire logic core_clk, // System clock, used only to vary floating pins.
  input wire logic [47:0] pinOut, // Device output levels.
  input wire logic [47:0] pinOe, // Device output enables.
  input wire logic [47:0] pullOn, // Device pull-ups switched on.
  input wire logic [47:0] extLevel, // Switch levels.
  input wire logic [47:0] extEn, // Switch closed, overpowers the pin.
  output logic [47:0] pinIn // Resolved pad levels.
);
  // A floating pad shows a pattern that changes each cycle, so no stale level can pass as valid.
  logic [47:0] floatPat = 48'h5555_5555_5555;
  always @(posedge core_clk) floatPat <= ~floatPat;
  // Switches hold their level steady between changes the bench makes.
  assign pinIn = (extEn & extLevel) | (~extEn & pinOe & pinOut) | (~extEn & ~pinOe & pullOn)
    | (~extEn & ~pinOe & ~pullOn & floatPat);
endmodule

`default_nettype wire

//--- tb/gpw_ports_test.sv
// Self-checking bench for the general-purpose port block.
// Assumes the design of rtl/ and the pin model of tb/ are compiled first.
`timescale 1ns/1ns
`default_nettype none

module gpw_ports_test;
  import gpw_pkg::*;
  logic core_clk = 0, rst = 1, keepOnReset = 0, memWrEn = 0, memRdEn = 0, sleepMode = 0, wakeReq;
  logic [4:0] memAddr = 5'h00;
  logic [7:0] memWrData = 8'h00, memRdData, d;
  logic [47:0] pinIn, pinOut, pinOe, pullOn, pullStrong, pinGpio = '1, pinNmos = '0, extLevel = '0, extEn = '0;
  logic [23:0] driveLevel;
  int bad_count = 0, comparisons = 0;

  gpw_ports DUT (.core_clk(core_clk), .rst(rst), .keepOnReset(keepOnReset), .memAddr(memAddr),
    .memWrEn(memWrEn), .memWrData(memWrData), .memRdEn(memRdEn), .memRdData(memRdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .pinGpio(pinGpio), .pinNmos(pinNmos), .pullOn(pullOn),
    .pullStrong(pullStrong), .driveLevel(driveLevel), .sleepMode(sleepMode), .wakeReq(wakeReq));
  gpw_pin_model pads (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe), .pullOn(pullOn),
    .extLevel(extLevel), .extEn(extEn), .pinIn(pinIn));

  initial forever #25 core_clk = ~core_clk;

  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge core_clk);
    memAddr <= a; memWrData <= v; memWrEn <= 1;
    @(posedge core_clk);
    memWrEn <= 0;
    // Let the register update of the taking edge settle before any caller compares outputs.
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge core_clk);
    memAddr <= a; memRdEn <= 1;
    @(posedge core_clk);
    memRdEn <= 0;
    #1 v = memRdData;
  endtask
  task automatic do_reset(input logic keep);
    @(posedge core_clk);
    rst <= 1; keepOnReset <= keep;
    repeat (2) @(posedge core_clk);
    rst <= 0; keepOnReset <= 0;
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_reset_values;
    for (int p = 0; p < 6; p++) begin
      rd(DIR_IDX[p], d); chk("dir", d, PIN_MASK[p]);
      rd(PU_IDX[p], d); chk("pull", d, 0);
    end
    rd(WAKE_IDX, d); chk("wake", d, 0);
    rd(STRENGTH_IDX, d); chk("strength", d, 0);
    chk("drive", driveLevel, 0);
    chk("oe", pinOe, 0);
  endtask
  task automatic t_output_latch;
    wr(DIR_IDX[0], 8'h00); wr(DATA_IDX[0], 8'h5a);
    extLevel[7:0] <= 8'ha5; extEn[7:0] <= 8'hff;
    wr(DATA_IDX[1], 8'h00); repeat (3) @(posedge core_clk);
    chk("out", pinOut[7:0], 8'h5a);
    chk("oe", pinOe[7:0], 8'hff);
    rd(DATA_IDX[0], d); chk("latch read", d, 8'h5a);
    extEn[7:0] <= 8'h00;
  endtask
  task automatic t_input_read;
    wr(DIR_IDX[0], 8'hff); extLevel[7:0] <= 8'hc3; extEn[7:0] <= 8'hff;
    repeat (3) @(posedge core_clk);
    chk("oe in", pinOe[7:0], 8'h00);
    rd(DATA_IDX[0], d); chk("live read", d, 8'hc3);
  endtask
  task automatic t_unimplemented;
    for (int p = 3; p < 6; p++) begin
      wr(PU_IDX[p], 8'hff); rd(PU_IDX[p], d); chk("pull mask", d, PIN_MASK[p]);
      wr(DIR_IDX[p], 8'h00); wr(DATA_IDX[p], 8'hff);
      chk("absent out", pinOut[8*p+:8], PIN_MASK[p]);
      chk("absent oe", pinOe[8*p+:8], PIN_MASK[p]);
    end
    wr(STRENGTH_IDX, 8'hff); rd(STRENGTH_IDX, d); chk("strength mask", d, 8'h01);
    rd(5'h17, d); chk("unmapped", d, 0);
  endtask
  task automatic t_pullup;
    wr(DIR_IDX[0], 8'h0f); wr(PU_IDX[0], 8'hff);
    chk("pull gpio", pullOn[7:0], 8'h0f);
    chk("strong", pullStrong[7:0], 8'h0f);
    pinNmos[7:0] <= 8'hf0; wr(STRENGTH_IDX, 8'h00);
    chk("pull nmos", pullOn[7:0], 8'hff);
    chk("weak", pullStrong[7:0], 8'h00);
    wr(PU_IDX[0], 8'h00); pinNmos <= '0; wr(STRENGTH_IDX, 8'h01);
    chk("pull off", pullStrong[7:0], 8'h00);
  endtask
  task automatic t_drive;
    for (int i = 0; i < 4; i++) begin
      wr(DRIVE0_IDX, 8'(i << 6)); chk("drive b hi", driveLevel[7:0], {i[1:0], 6'h00});
    end
    wr(DRIVE1_IDX, 8'h1b); wr(DRIVE2_IDX, 8'he4);
    chk("drive all", driveLevel, 24'he41bc0);
  endtask
  task automatic wake_try(input logic sl, input logic exp);
    logic seen;
    seen = 0;
    sleepMode <= sl; extLevel[0] <= 1; extEn[0] <= 1;
    repeat (4) @(posedge core_clk);
    extLevel[0] <= 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1 seen |= wakeReq;
    end
    chk("wake", seen, exp);
    if (exp && !seen) complete_run();
  endtask
  task automatic t_wake;
    wr(DIR_IDX[0], 8'hff); wr(WAKE_IDX, 8'h00); wake_try(1, 0);
    wr(WAKE_IDX, 8'h01); rd(WAKE_IDX, d); chk("wake reg", d, 8'h01);
    wake_try(0, 0);
    wake_try(1, 1);
    wr(DIR_IDX[0], 8'hfe); wake_try(1, 0);
    wr(DIR_IDX[0], 8'hff); pinGpio[0] <= 0; wake_try(1, 0);
    chk("oe alt", pinOe[0], 0);
    pinGpio[0] <= 1;
    sleepMode <= 0;
  endtask
  task automatic t_keep;
    wr(DIR_IDX[1], 8'h3c); do_reset(1);
    rd(DIR_IDX[1], d); chk("kept", d, 8'h3c);
    do_reset(0); rd(DIR_IDX[1], d); chk("cleared", d, 8'hff);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 0;
    t_reset_values(); t_output_latch(); t_input_read(); t_unimplemented();
    t_pullup(); t_drive(); t_wake(); t_keep();
    complete_run();
  end
  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end
endmodule

`default_nettype wire
